// ==== hw/sysclk_sel_defines.svh ====
`ifndef SYSCLK_SEL_DEFINES_SVH
`define SYSCLK_SEL_DEFINES_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_CFG_VIEW  8'h08
// selection codes
`define SEL_FAST_DIV    3'h7
`define SEL_LP_FAST_DIV 3'h6
`define SEL_LOW_RC      3'h5
`define SEL_SEC         3'h4
`define SEL_PRI_PLL     3'h3
`define SEL_PRI         3'h2
`define SEL_FAST_PLL    3'h1
`define SEL_FAST        3'h0
// primary mode codes
`define MODE_CRYSTAL_HI  2'h2
`define MODE_CRYSTAL_STD 2'h1
`define MODE_EXT_CLK     2'h0
`define MODE_INT         2'h3
// oscillator configuration word fields
`define CFG_OUTFN_BIT 2
`define CFG_SECPW_BIT 5
`define CFG_SWDIS_BIT 7
// control register fields
`define CTL_SEL_LSB   0
`define CTL_DIV_LSB   3
`define CTL_SWREQ_BIT 8
`define CTL_GPIO_BIT  9
`define CTL_GPOE_BIT  10
`define CTL_RESET     11'h000
// clock fail timeout
`define CLK_PERIOD_NS 100
`define FAIL_TIME_NS  100000
`define FAIL_CYCLES   ((`FAIL_TIME_NS) / (`CLK_PERIOD_NS))
`endif

// ==== hw/sysclk_sel_pkg.sv ====
package sysclk_sel_pkg;
   typedef enum logic [0:0] {ST_POR, ST_RUN} boot_state_t;
   typedef logic [2:0] sel_code_t;
endpackage

// ==== hw/system_clock_source_select.sv ====
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "sysclk_sel_defines.svh"
module system_clock_source_select
   import sysclk_sel_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  osc_config_word,
   input  wire logic [2:0]  osc_select_config_word,
   input  wire logic        primary_in_pin,
   input  wire logic        secondary_in_pin,
   input  wire logic        fast_rc_osc,
   input  wire logic        low_power_fast_rc_osc,
   input  wire logic        low_power_rc_osc,
   input  wire logic        pll_clock,
   output logic             sys_clock,
   output logic             instr_cycle_clock,
   output logic             pll_enable,
   output logic [1:0]       primary_mode_cfg,
   output logic [1:0]       ext_clock_range_cfg,
   output logic             secondary_power_select,
   output logic             clock_fail_monitor,
   output logic             clock_fail,
   output logic             primary_out_pin,
   output logic             primary_out_pin_oe_n
);

////////////////////////////////////////////////////////////////////////
// helpers

// true for selections that run from an internal oscillator
function automatic logic is_internal(input sel_code_t s);
   is_internal = (s == `SEL_FAST_DIV) || (s == `SEL_LP_FAST_DIV) ||
                 (s == `SEL_LOW_RC) || (s == `SEL_FAST_PLL) ||
                 (s == `SEL_FAST);
endfunction

// mode reported for a selection
function automatic logic [1:0] eff_mode(input sel_code_t s,
                                        input logic [1:0] m);
   if (is_internal(s))
      eff_mode = `MODE_INT;
   else if (s == `SEL_SEC)
      eff_mode = `MODE_EXT_CLK;
   else
      eff_mode = m;
endfunction

// post-divider toggle point, in source edges minus one
function automatic logic [7:0] div_limit(input logic [2:0] d);
   div_limit = ((8'h01 << d) >> 1) - 8'h01;
endfunction

////////////////////////////////////////////////////////////////////////
// apb slave

logic [10:0] ctrl;
logic [10:0] next_ctrl;
logic [31:0] next_prdata;
logic        next_pready;
logic        next_pslverr;
logic        access;
logic        sw_req;
boot_state_t st;
sel_code_t   act_sel;
logic [7:0]  act_cfg;
logic        sw_en;
logic        mon_en;

assign access = psel & penable & pready;
assign sw_req = access & pwrite & (paddr == `OFS_CTRL) & pwdata[`CTL_SWREQ_BIT];

// decode in setup phase, answer in access phase with no wait
always_comb begin
   next_ctrl    = ctrl;
   next_prdata  = prdata;
   next_pready  = 1'b0;
   next_pslverr = 1'b0;
   if (psel & ~penable) begin
      next_pready = 1'b1;
      case (paddr)
         `OFS_CTRL:     next_prdata = {21'h000000, ctrl};
         `OFS_STATUS:   next_prdata = {22'h000000, clock_fail, mon_en, sw_en,
                                       pll_enable, primary_mode_cfg, st == ST_RUN, act_sel};
         `OFS_CFG_VIEW: next_prdata = {24'h000000, act_cfg};
         default: begin
            next_prdata  = 32'h00000000;
            next_pslverr = 1'b1;
         end
      endcase
   end
   if (access & pwrite & (paddr == `OFS_CTRL)) begin
      next_ctrl = pwdata[10:0];
      next_ctrl[`CTL_SWREQ_BIT] = 1'b0; // request bit self-clears
   end
end

// bus registers
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      ctrl    <= `CTL_RESET;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      ctrl    <= next_ctrl;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
   end
end

////////////////////////////////////////////////////////////////////////
// power-on capture, clock switch and fail monitor

boot_state_t next_st;
sel_code_t   next_act_sel;
logic [7:0]  next_act_cfg;
logic        next_clock_fail;
logic [10:0] idle_cnt;
logic        fail_hit;

assign sw_en    = ~act_cfg[`CFG_SWDIS_BIT];
assign mon_en   = (act_cfg[7:6] == 2'h0);
assign fail_hit = mon_en & ~clock_fail & (idle_cnt == 11'(`FAIL_CYCLES));

// latch configuration once after reset release, then hold it; only a switch request or a clock fail changes the selection
always_comb begin
   next_st         = st;
   next_act_sel    = act_sel;
   next_act_cfg    = act_cfg;
   next_clock_fail = clock_fail;
   case (st)
      ST_POR: begin
         next_act_sel = osc_select_config_word;
         next_act_cfg = osc_config_word;
         next_st      = ST_RUN;
      end
      ST_RUN: begin
         if (fail_hit) begin
            next_clock_fail = 1'b1;
            next_act_sel    = `SEL_FAST;        // fall back to internal RC
         end else if (sw_req & sw_en) begin
            next_act_sel = pwdata[2:0];
         end
      end
      default: next_st = ST_POR;
   endcase
end

// capture registers; erased defaults until the capture
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      st         <= ST_POR;
      act_sel    <= `SEL_FAST_DIV;
      act_cfg    <= 8'hFF;
      clock_fail <= 1'b0;
   end else begin
      st         <= next_st;
      act_sel    <= next_act_sel;
      act_cfg    <= next_act_cfg;
      clock_fail <= next_clock_fail;
   end
end

////////////////////////////////////////////////////////////////////////
// source mux, post-divider and cycle clock

logic       src_raw;
logic       src_prev;
logic       src_rise;
logic [7:0] div_cnt;
logic       div_clk;
logic       use_div;
logic       next_src_raw;
logic [7:0] next_div_cnt;
logic       next_div_clk;
logic [10:0] next_idle_cnt;
logic       next_sys;
logic       next_instr;
logic [2:0] div_sel;

assign src_rise = src_raw & ~src_prev;
assign div_sel  = ctrl[`CTL_DIV_LSB +: 3];
assign use_div  = ((act_sel == `SEL_FAST_DIV) || (act_sel == `SEL_LP_FAST_DIV)) && (div_sel != 3'h0);

// select, divide and halve the running source
always_comb begin
   case (act_sel)
      `SEL_FAST_DIV, `SEL_FAST: next_src_raw = fast_rc_osc;
      `SEL_LP_FAST_DIV: next_src_raw = low_power_fast_rc_osc;
      `SEL_LOW_RC:    next_src_raw = low_power_rc_osc;
      `SEL_SEC:       next_src_raw = secondary_in_pin;
      `SEL_PRI_PLL, `SEL_FAST_PLL: next_src_raw = pll_clock;
      `SEL_PRI:       next_src_raw = primary_in_pin;
      default:        next_src_raw = fast_rc_osc;
   endcase
   next_div_cnt = div_cnt;
   next_div_clk = div_clk;
   if (!use_div) begin
      next_div_cnt = 8'h00;
   end else if (src_rise) begin
      if (div_cnt >= div_limit(div_sel)) begin
         next_div_cnt = 8'h00;
         next_div_clk = ~div_clk;
      end else begin
         next_div_cnt = div_cnt + 8'h01;
      end
   end
   next_sys = use_div ? div_clk : src_raw;
   next_instr = (next_sys & ~sys_clock) ? ~instr_cycle_clock : instr_cycle_clock;
   if (src_rise | ~mon_en | clock_fail)
      next_idle_cnt = 11'h000;
   else if (idle_cnt != 11'(`FAIL_CYCLES))
      next_idle_cnt = idle_cnt + 11'h001;
   else
      next_idle_cnt = idle_cnt;
end

// clock path registers
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      src_raw           <= 1'b0;
      src_prev          <= 1'b0;
      div_cnt           <= 8'h00;
      div_clk           <= 1'b0;
      idle_cnt          <= 11'h000;
      sys_clock         <= 1'b0;
      instr_cycle_clock <= 1'b0;
   end else begin
      src_raw           <= next_src_raw;
      src_prev          <= src_raw;
      div_cnt           <= next_div_cnt;
      div_clk           <= next_div_clk;
      idle_cnt          <= next_idle_cnt;
      sys_clock         <= next_sys;
      instr_cycle_clock <= next_instr;
   end
end

////////////////////////////////////////////////////////////////////////
// configuration outputs and output pin

logic [1:0] next_mode;
logic       next_pll;
logic       next_out;
logic       next_out_oe_n;
logic       crystal;

assign crystal = (next_mode == `MODE_CRYSTAL_HI) || (next_mode == `MODE_CRYSTAL_STD);

// derive reported mode, multiplier and pin use
always_comb begin
   next_mode     = eff_mode(act_sel, act_cfg[1:0]);
   next_pll      = (act_sel == `SEL_PRI_PLL) || (act_sel == `SEL_FAST_PLL);
   next_out      = 1'b0;
   next_out_oe_n = 1'b1;
   if (crystal) begin
      next_out_oe_n = 1'b1;                   // pin belongs to the crystal
   end else if (act_cfg[`CFG_OUTFN_BIT]) begin
      next_out      = next_instr;
      next_out_oe_n = 1'b0;
   end else begin
      next_out      = ctrl[`CTL_GPIO_BIT];
      next_out_oe_n = ~ctrl[`CTL_GPOE_BIT];
   end
end

// output registers
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pll_enable             <= 1'b0;
      primary_mode_cfg       <= `MODE_INT;
      ext_clock_range_cfg    <= 2'h3;
      secondary_power_select <= 1'b1;
      clock_fail_monitor     <= 1'b0;
      primary_out_pin        <= 1'b0;
      primary_out_pin_oe_n   <= 1'b1;
   end else begin
      pll_enable             <= next_pll;
      primary_mode_cfg       <= next_mode;
      ext_clock_range_cfg    <= act_cfg[4:3];
      secondary_power_select <= act_cfg[`CFG_SECPW_BIT];
      clock_fail_monitor     <= mon_en;
      primary_out_pin        <= next_out;
      primary_out_pin_oe_n   <= next_out_oe_n;
   end
end

////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

sequence s_switch_req;
   (st == ST_RUN) && sw_req && !fail_hit;
endsequence

// the release edge itself still runs the reset branch, so only sampled-high reset arms the capture checks
a_por_capture: assert property (presetn && (st == ST_POR) |=>
   (act_sel == $past(osc_select_config_word)) && (act_cfg == $past(osc_config_word)) && (st == ST_RUN))
   else $error("power-on capture wrong");
a_erased_default: assert property (presetn && (st == ST_POR) && (osc_select_config_word == 3'h7) |=>
   (act_sel == 3'h7) ##1 (primary_mode_cfg == 2'h3) && !pll_enable)
   else $error("erased default not divided fast rc");
a_pll_sources: assert property (pll_enable |->
   ($past(act_sel) == 3'h3) || ($past(act_sel) == 3'h1))
   else $error("multiplier on wrong source");
a_internal_mode: assert property ((st == ST_RUN) && is_internal(act_sel) |=>
   primary_mode_cfg == 2'h3)
   else $error("internal source mode not 11");
a_instr_half: assert property ($changed(instr_cycle_clock) == $rose(sys_clock))
   else $error("cycle clock not half rate");
a_switch_blocked: assert property (s_switch_req ##0 act_cfg[7] |=> $stable(act_sel))
   else $error("switch taken while disabled");
a_switch_taken: assert property (s_switch_req ##0 !act_cfg[7] |=> act_sel == $past(pwdata[2:0]))
   else $error("enabled switch not taken");
a_fail_monitor: assert property ($rose(clock_fail) |-> $past(act_cfg[7:6]) == 2'h0 ##1 clock_fail_monitor)
   else $error("fail flagged with monitor off");
a_fast_rc_route: assert property ((st == ST_RUN) && (act_sel == 3'h7) && $stable(act_sel) |=>
   src_raw == $past(fast_rc_osc))
   else $error("fast rc not routed");
a_out_clock: assert property (!next_out_oe_n && act_cfg[2] && !crystal |=>
   (primary_out_pin == instr_cycle_clock) && !primary_out_pin_oe_n)
   else $error("cycle clock not on output pin");

endmodule

// ==== bench/osc_partner.sv ====
`timescale 1ns/1ns
// free-running oscillator levels, all synchronous to the bus clock
module osc_partner (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic stall,
   output logic      primary_in_pin,
   output logic      secondary_in_pin,
   output logic      fast_rc_osc,
   output logic      low_power_fast_rc_osc,
   output logic      low_power_rc_osc,
   output logic      pll_clock
);
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   ////////////////////////////////////////////////////////////////
   // phase counter shared by every source
   always_comb begin
      next_cnt = cnt + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= 8'h00;
      else cnt <= next_cnt;
   end
   // fast RC, primary and PLL toggle each cycle, the others from higher bits
   assign fast_rc_osc           = cnt[0];
   assign low_power_fast_rc_osc = cnt[3];
   assign low_power_rc_osc      = cnt[5];
   assign primary_in_pin        = cnt[0];
   assign secondary_in_pin      = cnt[4] & ~stall; // stall starves the fail monitor
   assign pll_clock             = cnt[0];
endmodule

// ==== bench/system_clock_source_select_tb.sv ====
`timescale 1ns/1ns
module system_clock_source_select_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, osc_config_word;
   logic [31:0] pwdata, prdata, rnd;
   logic [2:0]  osc_select_config_word;
   logic        pin_p, pin_s, fast_rc, lp_fast_rc, lp_rc, pllc, stall, sys_clock, instr_cycle_clock, pll_enable;
   logic [1:0]  primary_mode_cfg, ext_clock_range_cfg;
   logic        secondary_power_select, clock_fail_monitor, clock_fail, primary_out_pin, primary_out_pin_oe_n;
   logic [32:0] exp_q[$], msk_q[$], me, mm;
   int          errors, cmp_count, r0, t0, r1, t1, p0;
   ////////////////////////////////////////////////////////////////
   system_clock_source_select u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_config_word(osc_config_word), .osc_select_config_word(osc_select_config_word),
      .primary_in_pin(pin_p), .secondary_in_pin(pin_s), .fast_rc_osc(fast_rc), .low_power_fast_rc_osc(lp_fast_rc),
      .low_power_rc_osc(lp_rc), .pll_clock(pllc), .sys_clock(sys_clock), .instr_cycle_clock(instr_cycle_clock),
      .pll_enable(pll_enable), .primary_mode_cfg(primary_mode_cfg), .ext_clock_range_cfg(ext_clock_range_cfg),
      .secondary_power_select(secondary_power_select), .clock_fail_monitor(clock_fail_monitor),
      .clock_fail(clock_fail), .primary_out_pin(primary_out_pin), .primary_out_pin_oe_n(primary_out_pin_oe_n));
   osc_partner u_osc (.pclk(pclk), .presetn(presetn), .stall(stall), .primary_in_pin(pin_p),
      .secondary_in_pin(pin_s), .fast_rc_osc(fast_rc), .low_power_fast_rc_osc(lp_fast_rc),
      .low_power_rc_osc(lp_rc), .pll_clock(pllc));
   ////////////////////////////////////////////////////////////////
   // 10 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task complete_run;
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one bus transfer; a read leaves its expected word and mask in the queue
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
      int n;
      if (!w) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         errors++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // read results are compared against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         me = exp_q.pop_front();
         mm = msk_q.pop_front();
         chk({pslverr, prdata} & mm, me & mm);
      end
   end
   task boot(input logic [7:0] c, input logic [2:0] s);
      presetn <= 1'b0;
      osc_config_word <= c;
      osc_select_config_word <= s;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   task cfg_check(input logic [7:0] c, input logic [2:0] s);
      logic [1:0] md;
      logic       pll;
      boot(c, s);
      md = (s >= 3'h5 || s <= 3'h1) ? 2'h3 : (s == 3'h4) ? 2'h0 : c[1:0];
      pll = (s == 3'h3) || (s == 3'h1);
      chk(pll_enable, pll);
      chk(primary_mode_cfg, md);
      chk(ext_clock_range_cfg, c[4:3]);
      chk(secondary_power_select, c[5]);
      chk(clock_fail_monitor, c[7:6] == 2'h0);
      apb(1'b0, 8'h04, 32'h0, {24'h0, c[7:6] == 2'h0, !c[7], pll, md, 1'b0, s}, 33'h1FFFFFFF7);
      apb(1'b0, 8'h08, 32'h0, {25'h0, c}, 33'h1000000FF);
   endtask
   // counts sys clock rises and instruction clock toggles
   task measure(output int r, output int t, output int p);
      logic ps, pi, pp;
      r = 0;
      t = 0;
      p = 0;
      ps = sys_clock;
      pi = instr_cycle_clock;
      pp = primary_out_pin;
      repeat (128) begin
         @(posedge pclk);
         if (sys_clock && !ps) r++;
         if (instr_cycle_clock !== pi) t++;
         if (primary_out_pin !== pp) p++;
         ps = sys_clock;
         pi = instr_cycle_clock;
         pp = primary_out_pin;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      errors = 0;
      cmp_count = 0;
      rnd = 32'h4B8C22FC;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      stall = 1'b0;
      presetn = 1'b0;
      osc_config_word = 8'hFF;
      osc_select_config_word = 3'h7;
      cfg_check(8'hFF, 3'h7);
      for (int i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         cfg_check(rnd[7:0], i[2:0]);
      end
      apb(1'b0, 8'h0C, 32'h0, 33'h100000000, 33'h1FFFFFFFF);
      boot(8'h3F, 3'h0);
      measure(r0, t0, p0);
      chk(t0, r0);
      chk(r0 > 0, 1'b1);
      boot(8'h3F, 3'h7);
      measure(r0, t0, p0);
      apb(1'b1, 8'h00, 32'h8, 33'h0, 33'h0);
      measure(r1, t1, p0);
      chk(r1 >= r0 / 2 - 1 && r1 <= r0 / 2 + 1, 1'b1);
      boot(8'h3F, 3'h0);
      apb(1'b1, 8'h00, 32'h102, 33'h0, 33'h0);
      apb(1'b0, 8'h04, 32'h0, 33'h2, 33'h7);
      boot(8'hBF, 3'h0);
      apb(1'b1, 8'h00, 32'h102, 33'h0, 33'h0);
      apb(1'b0, 8'h04, 32'h0, 33'h0, 33'h7);
      boot(8'h04, 3'h2);
      chk(primary_out_pin_oe_n, 1'b0);
      measure(r0, t0, p0);
      chk(p0, t0);
      chk(t0 > 0, 1'b1);
      boot(8'h00, 3'h2);
      apb(1'b1, 8'h00, 32'h600, 33'h0, 33'h0);
      repeat (2) @(posedge pclk);
      chk({primary_out_pin, primary_out_pin_oe_n}, 2'h2);
      boot(8'h02, 3'h2);
      chk(primary_out_pin_oe_n, 1'b1);
      // starved source: no fail while the monitor is off, fail and fallback while it is on
      boot(8'h7F, 3'h4);
      stall <= 1'b1;
      repeat (1100) @(posedge pclk);
      chk(clock_fail, 1'b0);
      boot(8'h3F, 3'h4);
      stall <= 1'b1;
      repeat (1100) @(posedge pclk);
      chk({clock_fail, clock_fail_monitor}, 2'h3);
      apb(1'b0, 8'h04, 32'h0, 33'h300, 33'h100000307);
      stall <= 1'b0;
      chk(exp_q.size(), 0);
      complete_run();
   end
endmodule
